// ==== shared/fhrm_pkg.sv ====
// package: holding-register map constants and carrier types
package fhrm_pkg;

    // ------------------------------------------------------------
    // register numbers (request address plus base)
    // ------------------------------------------------------------
    localparam logic [16:0] RN_BASE        = 17'h09C41;
    localparam logic [16:0] RN_STATUS      = 17'h09C43;
    localparam logic [16:0] RN_STATUS_M1   = 17'h09C48;
    localparam logic [16:0] RN_STATUS_M2   = 17'h09C89;
    localparam logic [16:0] RN_CAL_CMD     = 17'h09C5E;
    localparam logic [16:0] RN_SPAN_HI     = 17'h09C5F;
    localparam logic [16:0] RN_SPAN_LO     = 17'h09C60;
    localparam logic [16:0] RN_CAL_STAT    = 17'h09C61;
    localparam logic [16:0] RN_GAP0_FIRST  = 17'h09C62;
    localparam logic [16:0] RN_GAP0_LAST   = 17'h09C67;
    localparam logic [16:0] RN_PROC_STATE  = 17'h09CB2;
    localparam logic [16:0] RN_FILTER      = 17'h0A410;
    localparam logic [16:0] RN_GAP1        = 17'h0A411;
    localparam logic [16:0] RN_ZERO_RANGE  = 17'h0A412;
    localparam logic [16:0] RN_AZT         = 17'h0A413;
    localparam logic [16:0] RN_GAP2        = 17'h0A414;
    localparam logic [16:0] RN_MOTION      = 17'h0A415;
    localparam logic [16:0] RN_GAP3        = 17'h0A416;
    localparam logic [16:0] RN_GAP4        = 17'h0A417;
    localparam logic [16:0] RN_CAP_HI      = 17'h0A418;
    localparam logic [16:0] RN_CAP_LO      = 17'h0A419;
    localparam logic [16:0] RN_DEC_POINT   = 17'h0A41A;
    localparam logic [16:0] RN_INCREMENT   = 17'h0A41B;
    localparam logic [16:0] RN_FEED_TYPE   = 17'h0A475;
    localparam logic [16:0] RN_PREACT      = 17'h0A476;
    localparam logic [16:0] RN_GAP5        = 17'h0A477;
    localparam logic [16:0] RN_CHECK_DLY   = 17'h0A478;
    localparam logic [16:0] RN_ZERO_PER    = 17'h0A479;
    localparam logic [16:0] RN_ZERO_DLY    = 17'h0A47A;
    localparam logic [16:0] RN_END_IND     = 17'h0A47B;
    localparam logic [16:0] RN_FEED_CHK    = 17'h0A47C;
    localparam logic [16:0] RN_MAX_FILL    = 17'h0A47D;

    // ------------------------------------------------------------
    // storage slots, status bits, codes
    // ------------------------------------------------------------
    localparam int          N_SLOT   = 18;
    localparam logic [4:0]  SL_CAP_HI  = 5'h04;
    localparam logic [4:0]  SL_DEC_PT  = 5'h06;
    localparam logic [4:0]  SL_INC     = 5'h07;
    localparam logic [4:0]  SL_SPAN_HI = 5'h10;
    localparam logic [4:0]  SL_SPAN_LO = 5'h11;
    localparam logic [15:0] CFG_RST    = 16'h0000;
    localparam logic [15:0] INC_RST    = 16'h0001;
    localparam logic [15:0] DEC_PT_MAX = 16'h0005;
    localparam logic [15:0] INC_MIN    = 16'h0001;
    localparam logic [15:0] INC_MAX    = 16'h0003;
    localparam int          BIT_BUSY   = 0;
    localparam int          BIT_VALID  = 1;
    localparam int          BIT_PERR   = 5;
    localparam logic [7:0]  FC_READ    = 8'h03;
    localparam logic [7:0]  FC_WR1     = 8'h06;
    localparam logic [7:0]  FC_WRN     = 8'h10;
    localparam logic [7:0]  EXC_NONE   = 8'h00;
    localparam logic [7:0]  EXC_FUNC   = 8'h01;
    localparam logic [7:0]  EXC_ADDR   = 8'h02;
    localparam logic [7:0]  EXC_VALUE  = 8'h03;
    localparam logic [7:0]  EXC_OPER   = 8'h04;
    localparam logic [15:0] CMD_ZERO   = 16'h00BC;
    localparam logic [15:0] CMD_SPAN   = 16'h00DC;
    localparam logic [7:0]  CS_READY   = 8'h01;
    localparam logic [7:0]  CS_ZERO    = 8'h03;
    localparam logic [7:0]  CS_SPAN    = 8'h04;
    localparam logic [7:0]  CS_FAIL    = 8'h09;

    typedef enum logic [3:0] {
        CAL_READY = 4'h1,
        CAL_ZERO  = 4'h2,
        CAL_SPAN  = 4'h4,
        CAL_FAIL  = 4'h8
    } fhrm_cal_e;

    typedef enum logic [2:0] {
        PH_NONE    = 3'h0,
        PH_READY   = 3'h1,
        PH_FILLING = 3'h2,
        PH_FULL    = 3'h3,
        PH_DISCH   = 3'h4,
        PH_FLOWDLY = 3'h5
    } fhrm_phase_e;

    typedef struct packed {
        logic [7:0]  fc;
        logic [15:0] addr;
        logic [15:0] wdata;
    } fhrm_req_s;

    typedef struct packed {
        logic [7:0]  exc;
        logic [15:0] rdata;
    } fhrm_rsp_s;

    typedef struct packed {
        logic busy;
        logic valid;
        logic perr;
    } fhrm_flags_s;

endpackage : fhrm_pkg

// ==== core/fhrm_byte_tx.sv ====
// module: response word to byte stream, high byte first
`timescale 1ns/1ps
module fhrm_byte_tx
    import fhrm_pkg::*;
#(
    parameter int WORD_W = 16
) (
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    input  wire logic              in_valid,
    input  wire logic [WORD_W-1:0] in_word,
    output logic                   in_ready,
    output logic [7:0]             out_byte,
    output logic                   out_valid,
    input  wire logic              out_ready
);
    localparam int NB = WORD_W / 8;
    localparam int CW = $clog2(NB + 1);

    generate
        if (WORD_W % 8 != 0 || WORD_W < 8) begin : g_bad_width
            $error("fhrm_byte_tx: WORD_W must be a multiple of 8");
        end
    endgenerate

    logic [WORD_W-1:0] shreg;
    logic [CW-1:0]     left;
    wire               take_in  = in_valid && in_ready;
    wire               take_out = out_valid && out_ready;

    assign in_ready  = (left == '0);
    assign out_valid = (left != '0);
    assign out_byte  = shreg[WORD_W-1 -: 8];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            shreg <= '0;
            left  <= '0;
        end else if (take_in) begin
            shreg <= in_word;  // RQ15
            left  <= CW'(NB);
        end else if (take_out) begin
            shreg <= shreg << 8;
            left  <= left - CW'(1);
        end
    end

    high_first_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // RQ15
        take_in |=> out_valid && out_byte == $past(in_word[WORD_W-1 -: 8]))
        else $error("first byte out is not the high byte");

endmodule : fhrm_byte_tx

// ==== core/fhrm_cal_seq.sv ====
// module: zero and span calibration sequencer
`timescale 1ns/1ps
module fhrm_cal_seq
    import fhrm_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        go_zero,
    input  wire logic        go_span,
    input  wire logic        stat_ack,
    input  wire logic        cal_done,
    input  wire logic        cal_fail,
    input  wire logic [7:0]  cal_err,
    output logic             ready,
    output logic [15:0]      status,
    output logic             zero_start,
    output logic             span_start
);
    fhrm_cal_e  state;
    fhrm_cal_e  next_state;
    logic [7:0] err_q;
    logic [7:0] code;
    wire        running = (state == CAL_ZERO) || (state == CAL_SPAN);

    always_comb begin
        next_state = state;
        unique case (state)
            CAL_READY: begin
                if (go_zero) next_state = CAL_ZERO;      // RQ7
                else if (go_span) next_state = CAL_SPAN;
            end
            CAL_ZERO, CAL_SPAN: begin
                if (cal_fail) next_state = CAL_FAIL;     // RQ11
                else if (cal_done) next_state = CAL_READY;
            end
            CAL_FAIL: begin
                if (stat_ack) next_state = CAL_READY;
            end
            default: next_state = CAL_READY;
        endcase
    end

    assign code = (state == CAL_ZERO) ? CS_ZERO :   // RQ8
                  (state == CAL_SPAN) ? CS_SPAN :   // RQ10
                  (state == CAL_FAIL) ? CS_FAIL :   // RQ11
                  CS_READY;                         // RQ6
    assign ready  = (state == CAL_READY);
    assign status = {err_q, code};

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state      <= CAL_READY;
            err_q      <= 8'h00;
            zero_start <= 1'b0;
            span_start <= 1'b0;
        end else begin
            state      <= next_state;
            zero_start <= ready && go_zero;
            span_start <= ready && go_span && !go_zero;
            if (running && cal_fail) err_q <= cal_err;  // RQ11
            else if (next_state == CAL_READY) err_q <= 8'h00;
        end
    end

endmodule : fhrm_cal_seq

// ==== core/fhrm_holding_regs.sv ====
// module: holding-register bank behind the per-word Modbus access port
// ------------------------------------------------------------
// Functional notes
// (RQ1) process-state word reports phase code 0..5
// (RQ2) status word readable at primary and two mirror numbers
// (RQ3) master checks busy clear, valid set, error clear first
// (RQ4) master polls status while busy is set
// (RQ5) master reads error code or process error register
// (RQ6) calibration status low byte 1 means ready for a command
// (RQ7) command 188 to the command word starts zero calibration
// (RQ8) low byte 3 during zero calibration, then back to 1
// (RQ9) master writes span words before span command 220
// (RQ10) low byte 4 during span calibration, then back to 1
// (RQ11) failure gives low byte 9 and cause in high byte
// (RQ12) capacity is two words after a two-word gap
// (RQ13) unused numbers accept writes silently, read zero
// (RQ14) decimal point codes 0..5, increment codes 1..3
// (RQ15) words high byte first, multi-word values high word first
// (RQ16) exception codes 1 function, 2 address, 3 value, 4 operation
// ------------------------------------------------------------
`timescale 1ns/1ps
module fhrm_holding_regs
    import fhrm_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        req_valid,
    input  wire fhrm_req_s   req,
    output logic             req_ready,
    output logic             rsp_valid,
    output fhrm_rsp_s        rsp,
    output logic [7:0]       tx_byte,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    input  wire fhrm_flags_s flags,
    input  wire fhrm_phase_e phase,
    output logic             cal_zero_start,
    output logic             cal_span_start,
    output logic [31:0]      span_value,
    output logic [31:0]      capacity,
    input  wire logic        cal_done,
    input  wire logic        cal_fail,
    input  wire logic [7:0]  cal_err,
    output logic [15:0]      cfg_words [N_SLOT]
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic [5:0] slot_of(input logic [16:0] rn);
        logic [5:0] s;
        s = 6'h00;
        unique case (rn)
            RN_FILTER:     s = 6'h20;
            RN_ZERO_RANGE: s = 6'h21;
            RN_AZT:        s = 6'h22;
            RN_MOTION:     s = 6'h23;
            RN_CAP_HI:     s = 6'h24;
            RN_CAP_LO:     s = 6'h25;
            RN_DEC_POINT:  s = 6'h26;
            RN_INCREMENT:  s = 6'h27;
            RN_FEED_TYPE:  s = 6'h28;
            RN_PREACT:     s = 6'h29;
            RN_CHECK_DLY:  s = 6'h2A;
            RN_ZERO_PER:   s = 6'h2B;
            RN_ZERO_DLY:   s = 6'h2C;
            RN_END_IND:    s = 6'h2D;
            RN_FEED_CHK:   s = 6'h2E;
            RN_MAX_FILL:   s = 6'h2F;
            RN_SPAN_HI:    s = 6'h30;
            RN_SPAN_LO:    s = 6'h31;
            default:       s = 6'h00;
        endcase
        return s;
    endfunction : slot_of

    function automatic logic is_gap(input logic [16:0] rn);
        return (rn >= RN_GAP0_FIRST && rn <= RN_GAP0_LAST)
            || rn == RN_GAP1 || rn == RN_GAP2 || rn == RN_GAP3
            || rn == RN_GAP4 || rn == RN_GAP5;
    endfunction : is_gap

    function automatic logic is_stat(input logic [16:0] rn);
        return rn == RN_STATUS || rn == RN_STATUS_M1
            || rn == RN_STATUS_M2;
    endfunction : is_stat

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    logic [15:0] cfg_q [N_SLOT];
    logic        rd_q;
    logic        ser_ready;
    logic        cal_ready;
    logic [15:0] cal_status;

    wire         take      = req_valid && req_ready;
    wire  [16:0] rnum      = {1'b0, req.addr} + RN_BASE;
    wire         fc_read   = (req.fc == FC_READ);
    wire         fc_write  = (req.fc == FC_WR1) || (req.fc == FC_WRN);
    wire         fc_ok     = fc_read || fc_write;
    wire  [5:0]  slot_raw  = slot_of(rnum);
    wire         hit_slot  = slot_raw[5];
    wire  [4:0]  slot      = slot_raw[4:0];
    wire         hit_gap   = is_gap(rnum);
    wire         hit_stat  = is_stat(rnum);
    wire         hit_proc  = (rnum == RN_PROC_STATE);
    wire         hit_cstat = (rnum == RN_CAL_STAT);
    wire         hit_cmd   = (rnum == RN_CAL_CMD);
    wire         hit_ro    = hit_stat || hit_proc || hit_cstat;
    wire         mapped    = hit_slot || hit_gap || hit_ro || hit_cmd;

    wire         cmd_zero  = (req.wdata == CMD_ZERO);
    wire         cmd_span  = (req.wdata == CMD_SPAN);
    wire         cmd_known = cmd_zero || cmd_span;
    wire         dp_ok     = req.wdata <= DEC_PT_MAX;
    wire         inc_ok    = req.wdata >= INC_MIN && req.wdata <= INC_MAX;
    wire         val_ok    = (slot == SL_DEC_PT) ? dp_ok :   // RQ14
                             (slot == SL_INC)    ? inc_ok :  // RQ14
                             1'b1;

    wire  [15:0] stat_word = {10'h000, flags.perr, 3'b000,
                              flags.valid, flags.busy};

    // ------------------------------------------------------------
    // exception selection
    // ------------------------------------------------------------
    wire  [7:0]  exc =
        !fc_ok                                  ? EXC_FUNC :   // RQ16
        !mapped                                 ? EXC_ADDR :   // RQ16
        (fc_write && hit_ro)                    ? EXC_OPER :   // RQ16
        (fc_write && hit_cmd && !cmd_known)     ? EXC_VALUE :  // RQ16
        (fc_write && hit_cmd && !cal_ready)     ? EXC_OPER :   // RQ6
        (fc_write && hit_slot && !val_ok)       ? EXC_VALUE :  // RQ14
        EXC_NONE;

    wire         ok       = (exc == EXC_NONE);
    wire         wr_ok    = take && fc_write && ok;
    wire         wr_slot  = wr_ok && hit_slot;
    wire         go_zero  = wr_ok && hit_cmd && cmd_zero;   // RQ7
    wire         go_span  = wr_ok && hit_cmd && cmd_span;
    wire         stat_ack = take && fc_read && ok && hit_cstat;

    // ------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------
    wire  [15:0] rd_data =
        !ok       ? 16'h0000 :
        hit_stat  ? stat_word :                     // RQ2
        hit_proc  ? {13'h0000, phase} :             // RQ1
        hit_cstat ? cal_status :                    // RQ6
        hit_slot  ? cfg_q[slot] :
        16'h0000;                                   // RQ13

    // ------------------------------------------------------------
    // response and handshake
    // ------------------------------------------------------------
    assign req_ready = ser_ready && !rsp_valid;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rsp_valid <= 1'b0;
            rsp       <= '0;
            rd_q      <= 1'b0;
        end else begin
            rsp_valid <= take;
            rd_q      <= take && fc_read && ok;
            if (take) begin
                rsp.exc   <= exc;
                rsp.rdata <= rd_data;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration storage
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < N_SLOT; i++) begin
                cfg_q[i] <= (5'(i) == SL_INC) ? INC_RST : CFG_RST;
            end
        end else if (wr_slot) begin
            cfg_q[slot] <= req.wdata;   // RQ12
        end
    end

    assign cfg_words  = cfg_q;
    assign capacity   = {cfg_q[SL_CAP_HI], cfg_q[SL_CAP_HI + 5'h01]}; // RQ15
    assign span_value = {cfg_q[SL_SPAN_HI], cfg_q[SL_SPAN_LO]};       // RQ15

    // ------------------------------------------------------------
    // calibration and byte output
    // ------------------------------------------------------------
    fhrm_cal_seq u_cal (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .go_zero    (go_zero),
        .go_span    (go_span),
        .stat_ack   (stat_ack),
        .cal_done   (cal_done),
        .cal_fail   (cal_fail),
        .cal_err    (cal_err),
        .ready      (cal_ready),
        .status     (cal_status),
        .zero_start (cal_zero_start),
        .span_start (cal_span_start)
    );

    fhrm_byte_tx #(
        .WORD_W (16)
    ) u_tx (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .in_valid  (rsp_valid && rd_q),
        .in_word   (rsp.rdata),
        .in_ready  (ser_ready),
        .out_byte  (tx_byte),
        .out_valid (tx_valid),
        .out_ready (tx_ready)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    wire [7:0] cs_lo = cal_status[7:0];
    wire [7:0] cs_hi = cal_status[15:8];

    mirror_same_a: assert property ( // RQ2
        take && fc_read && hit_stat |=> rsp_valid && rsp.exc == EXC_NONE
            && rsp.rdata == $past(stat_word))
        else $error("status mirror read mismatch");

    phase_code_a: assert property ( // RQ1
        take && fc_read && hit_proc |=> rsp.rdata == {13'h0000, $past(phase)}
            && rsp.rdata <= 16'h0005)
        else $error("process state read wrong");

    zero_trigger_a: assert property ( // RQ7
        take && fc_write && hit_cmd && cmd_zero && cal_ready
            |=> cal_zero_start && cs_lo == CS_ZERO)
        else $error("zero command did not start calibration");

    zero_hold_a: assert property ( // RQ8 RQ10
        (cs_lo == CS_ZERO || cs_lo == CS_SPAN) && !cal_done && !cal_fail |=> $stable(cs_lo))
        else $error("calibration status dropped early");

    zero_end_a: assert property ( // RQ8
        cs_lo == CS_ZERO && cal_done && !cal_fail |=> cs_lo == CS_READY)
        else $error("zero calibration did not return to ready");

    span_run_a: assert property ( // RQ10
        take && fc_write && hit_cmd && cmd_span && cal_ready
            |=> cal_span_start && cs_lo == CS_SPAN)
        else $error("span calibration status wrong");

    span_end_a: assert property ( // RQ10
        cs_lo == CS_SPAN && cal_done && !cal_fail |=> cs_lo == CS_READY)
        else $error("span calibration did not return to ready");

    fail_cause_a: assert property ( // RQ11
        (cs_lo == CS_ZERO || cs_lo == CS_SPAN) && cal_fail
            |=> cs_lo == CS_FAIL && cs_hi == $past(cal_err))
        else $error("calibration failure not reported");

    not_ready_a: assert property ( // RQ6
        take && fc_write && hit_cmd && cmd_known && !cal_ready
            |=> rsp.exc == EXC_OPER && !cal_zero_start && !cal_span_start)
        else $error("command accepted while not ready");

    gap_zero_a: assert property ( // RQ13
        take && hit_gap && fc_ok |=> rsp.exc == EXC_NONE && rsp.rdata == 16'h0000)
        else $error("unused location misbehaved");

    capacity_word_a: assert property ( // RQ12
        take && fc_write && rnum == RN_CAP_HI |=> capacity[31:16] == $past(req.wdata))
        else $error("capacity high word not stored");

    dec_range_a: assert property ( // RQ14
        take && fc_write && rnum == RN_DEC_POINT && req.wdata > DEC_PT_MAX
            |=> rsp.exc == EXC_VALUE && cfg_words[SL_DEC_PT] == $past(cfg_words[SL_DEC_PT]))
        else $error("bad decimal point code accepted");

    exc_code_a: assert property ( // RQ16
        take |=> rsp.exc == ($past(!fc_ok) ? EXC_FUNC
            : $past(!mapped) ? EXC_ADDR : rsp.exc))
        else $error("wrong exception code");

    zero_cal_c: cover property (cal_zero_start ##[1:50] cal_status[7:0] == CS_READY);
    span_cal_c: cover property (cal_span_start ##[1:50] cal_status[7:0] == CS_FAIL);
    read_byte_c: cover property (take && fc_read && hit_stat ##[1:8] tx_valid && tx_ready);
    exc_c:       cover property (rsp_valid && rsp.exc == EXC_VALUE);

endmodule : fhrm_holding_regs

// ==== testbench/fhrm_master_model.sv ====
// partner model: fieldbus master issuing one-word requests
`timescale 1ns/1ps
module fhrm_master_model
    import fhrm_pkg::*;
(
    input  wire logic       clk_sys,
    output logic            req_valid,
    output fhrm_req_s       req,
    input  wire logic       req_ready,
    input  wire logic       rsp_valid,
    input  wire fhrm_rsp_s  rsp,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic       stall
);
    initial begin
        req_valid = 1'b0;
        req       = '0;
        tx_ready  = 1'b1;
    end

    // ----
    // one request: held until taken, answer one cycle later
    // ----
    task automatic xfer(input logic [7:0] fc, input logic [15:0] addr, input logic [15:0] wdata,
                        output logic [7:0] exc, output logic [15:0] word);
        int n;
        int k;
        word = 'x;
        k    = 0;
        n    = 0;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req       <= '{fc, addr, wdata};
        do begin
            @(posedge clk_sys);
            n++;
        end while (!req_ready && n < 50);
        req_valid <= 1'b0;
        req       <= ~req;
        @(posedge clk_sys);
        exc = rsp_valid ? rsp.exc : 8'hFF;
        for (n = 0; n < 50 && k < 2 && fc == FC_READ && exc == EXC_NONE; n++) begin
            @(posedge clk_sys);
            if (tx_valid && tx_ready) begin
                word = {word[7:0], tx_byte};
                k++;
            end
            tx_ready <= (stall && k < 2) ? ~tx_ready : 1'b1;
        end
    endtask : xfer

    // polls the status word while busy, at most 20 reads
    task automatic poll_status(output logic [15:0] st);
        logic [7:0] e;
        int         n;
        n = 0;
        do begin
            xfer(FC_READ, 16'h0002, 16'h0000, e, st);
            n++;
        end while (st[BIT_BUSY] !== 1'b0 && n < 20);
    endtask : poll_status
endmodule : fhrm_master_model

// ==== testbench/tb_fieldbus_holding_register_map.sv ====
// testbench: holding-register bank
`timescale 1ns/1ps
module tb_fieldbus_holding_register_map;
    import fhrm_pkg::*;
    typedef struct packed {
        logic [7:0]  fc;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [7:0]  exc;
        logic [15:0] rdata;
    } fhrm_row_s;

    logic        clk_sys = 1'b0, arst_n = 1'b0, req_valid, req_ready, rsp_valid, tx_valid, tx_ready;
    logic        stall = 1'b0, cal_done = 1'b0, cal_fail = 1'b0, cal_zero_start, cal_span_start;
    logic [7:0]  tx_byte, cal_err = 8'h00, e;
    logic [15:0] w, cfg_words [N_SLOT];
    logic [31:0] span_value, capacity;
    logic [1:0]  starts = 2'b00;
    fhrm_req_s   req;
    fhrm_rsp_s   rsp;
    fhrm_flags_s flags = '{1'b0, 1'b1, 1'b1};
    fhrm_phase_e phase = PH_FULL;
    fhrm_row_s   rows [$];
    int          mismatches = 0, total_checks = 0, cycles = 0;

    always #2 clk_sys = ~clk_sys;

    fhrm_holding_regs fhrm_holding_regs_inst (.clk_sys(clk_sys), .arst_n(arst_n), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .tx_byte(tx_byte),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .flags(flags), .phase(phase),
        .cal_zero_start(cal_zero_start), .cal_span_start(cal_span_start), .span_value(span_value),
        .capacity(capacity), .cal_done(cal_done), .cal_fail(cal_fail), .cal_err(cal_err),
        .cfg_words(cfg_words));
    fhrm_master_model fhrm_master_model_inst (.clk_sys(clk_sys), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .tx_byte(tx_byte),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .stall(stall));

    always @(posedge clk_sys) begin
        starts <= starts | {cal_zero_start, cal_span_start};
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end

    // ----
    // helpers
    // ----
    function automatic fhrm_row_s rd(input logic [15:0] a, input logic [15:0] d);
        return '{FC_READ, a, 16'h0000, EXC_NONE, d};
    endfunction : rd

    function automatic fhrm_row_s wr(input logic [15:0] a, input logic [15:0] d, input logic [7:0] x);
        return '{FC_WR1, a, d, x, 16'h0000};
    endfunction : wr

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic run_row(input fhrm_row_s r);
        fhrm_master_model_inst.xfer(r.fc, r.addr, r.wdata, e, w);
        chk({24'h0, e}, {24'h0, r.exc});
        if (r.fc == FC_READ && r.exc == EXC_NONE) chk({16'h0, w}, {16'h0, r.rdata});
    endtask : run_row

    task automatic pulse_cal(input logic fail);
        @(posedge clk_sys);
        cal_done <= ~fail;
        cal_fail <= fail;
        @(posedge clk_sys);
        cal_done <= 1'b0;
        cal_fail <= 1'b0;
    endtask : pulse_cal

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop

    // ----
    // main sequence
    // ----
    initial begin
        rows = {rd(16'h0002, 16'h0022), rd(16'h0007, 16'h0022), rd(16'h0048, 16'h0022),
            rd(16'h0071, 16'h0003), rd(16'h0020, 16'h0001),
            wr(16'h07CF, 16'h1234, 8'h00), rd(16'h07CF, 16'h1234),
            wr(16'h07D7, 16'h0001, 8'h00), wr(16'h07D8, 16'h86A0, 8'h00), rd(16'h07D7, 16'h0001),
            rd(16'h07D8, 16'h86A0), wr(16'h07D5, 16'hFFFF, 8'h00), rd(16'h07D5, 16'h0000),
            wr(16'h07D9, 16'h0005, 8'h00), wr(16'h07D9, 16'h0006, 8'h03), rd(16'h07D9, 16'h0005),
            wr(16'h07DA, 16'h0000, 8'h03), wr(16'h07DA, 16'h0004, 8'h03), wr(16'h07DA, 16'h0003, 8'h00),
            rd(16'h07DA, 16'h0003), wr(16'h0002, 16'h0000, 8'h04), rd(16'h00C7, 16'h0000),
            wr(16'h001D, 16'h0055, 8'h03)};
        rows[21].exc = EXC_ADDR;
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        chk({req_ready, rsp_valid, tx_valid}, 3'b100);
        chk({16'h0, cfg_words[SL_INC]}, {16'h0, INC_RST});
        foreach (rows[i]) run_row(rows[i]);
        chk(capacity, 32'h000186A0);
        run_row(wr(16'h001E, 16'h0000, 8'h00));
        run_row(wr(16'h001F, 16'hC350, 8'h00));
        chk(span_value, 32'h0000C350);
        run_row(wr(16'h001D, CMD_SPAN, 8'h00));
        run_row(rd(16'h0020, 16'h0004));
        run_row(wr(16'h001D, CMD_ZERO, EXC_OPER));
        chk({30'h0, starts}, 32'h1);
        pulse_cal(1'b0);
        run_row(rd(16'h0020, 16'h0001));
        run_row(wr(16'h001D, CMD_ZERO, 8'h00));
        run_row(rd(16'h0020, 16'h0003));
        chk({30'h0, starts}, 32'h3);
        cal_err <= 8'h23;
        pulse_cal(1'b1);
        run_row(rd(16'h0020, 16'h2309));
        run_row(rd(16'h0020, 16'h0001));
        for (int p = 0; p < 6; p++) begin
            phase <= fhrm_phase_e'(p);
            run_row(rd(16'h0071, 16'(p)));
        end
        flags <= '{1'b1, 1'b1, 1'b0};
        fork
            fhrm_master_model_inst.poll_status(w);
            begin
                repeat (40) @(posedge clk_sys);
                flags <= '{1'b0, 1'b1, 1'b0};
            end
        join
        chk({16'h0, w}, 32'h2);
        fhrm_master_model_inst.xfer(8'h04, 16'h0002, 16'h0000, e, w);
        chk({24'h0, e}, {24'h0, EXC_FUNC});
        stall <= 1'b1;
        run_row(rd(16'h07D8, 16'h86A0));
        stall <= 1'b0;
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        chk(capacity, 32'h0);
        run_row(rd(16'h07CF, 16'h0000));
        report_and_stop();
    end
endmodule : tb_fieldbus_holding_register_map
